// ==== common/mcs_pkg.sv ====
// Functional notes
// - Two-port partial: parity match sets gap timer
// - Gap hold keeps restore inhibit two cycles
// - Single-port: finish word before next request
// - Single-port: gap timer at every next strobe
// - Pass upper address, load counter from low
// - Word 0 start loads counter with 00
// - Counter holds until delayed read-restore, or write pulse on writes
// - Word flops cleared at acknowledge delay
// - Single-port: all four port selects held
// - Unblocked cycle start requests all four buses
// - Selected address acknowledge starts host acknowledge
// - Acknowledge sets mixer then request blocks
// - Read word buffered, valid on restore
// - Delayed load resets blocks, clears buffer
// - Last word cleared plus complete ends cycling
// - Writes: buffer loaded before any request
// - Write pulse gates data, sends restart
// - Immediate load fills buffer on writes
// - Write ends: no pending words, none occupied
// - Idle holds buffers and synchroniser cleared
package mcs_pkg;
	// Data and address widths
	localparam int DATA_W = 36;
	localparam int HADDR_W = 22;
	localparam int SADDR_W = 20;
	localparam int PORTS = 4;
	// Gap hold length in clock periods
	localparam logic [1:0] GAP_HOLD_CYCLES = 2'h2;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	// Control fields and reset value
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TWO_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// Status fields
	localparam int STAT_ACT_BIT = 0;
	localparam int STAT_GAP_BIT = 1;
	localparam int STAT_CNT_LSB = 2;
	localparam int STAT_WRQ_LSB = 4;
	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_SETUP, S_LOAD, S_REQ, S_ACKD, S_WPULSE,
		S_RDWAIT, S_NEXT, S_GAP, S_CLR, S_END
	} mcs_state_t;
endpackage

// ==== verilog/mcs_seq.sv ====
`timescale 1ns/1ps
module mcs_seq (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_sync_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Processor side
	input wire logic i_host_start,
	input wire logic i_host_cycle_type,
	input wire logic [3:0] i_host_word_requests,
	input wire logic [mcs_pkg::HADDR_W-1:0] i_host_addr,
	input wire logic [mcs_pkg::DATA_W-1:0] i_host_wdata,
	output logic o_host_acknowledge,
	output logic o_host_data_valid,
	output logic [mcs_pkg::DATA_W-1:0] o_host_rdata,
	// Storage side
	output logic [3:0] o_storage_cycle_request,
	output logic [mcs_pkg::SADDR_W-1:0] o_storage_addr,
	output logic [1:0] o_word_addr,
	output logic [3:0] o_port_data_gate,
	output logic [3:0] o_write_restart,
	output logic [mcs_pkg::DATA_W-1:0] o_storage_wdata,
	input wire logic [3:0] i_addr_ack,
	input wire logic [3:0] i_read_restore_done,
	input wire logic [mcs_pkg::DATA_W-1:0] i_storage_rdata,
	input wire logic [3:0] i_port_occupied
);
	import mcs_pkg::*;

	mcs_state_t state_q; // Sequencer state
	logic [1:0] ctrl_q; // Enable and two-port mode
	logic [1:0] cnt_q; // Word address counter
	logic [3:0] wreq_q; // Per-word request flops
	logic write_q; // Latched cycle type, high for write
	logic cycle_start_flag_q;
	logic cycle_active_q;
	logic even_request_block_q;
	logic odd_request_block_q;
	logic even_mixer_block_q;
	logic odd_mixer_block_q;
	logic buf_loaded_q; // Write buffer holds a word
	logic restore_inhibit_q;
	logic gap_hold_q;
	logic [1:0] gap_cnt_q; // Remaining gap hold periods
	logic [3:0] ack_port_q; // Port that acknowledged
	logic [DATA_W-1:0] buf_q; // Port data buffer
	logic [3:0] port_select; // All ports in single-port mode
	logic words_pending;
	logic ack_hit;
	logic rrs_hit;
	logic req_ok;
	logic [1:0] nxt_word;
	logic [1:0] inc_val;
	logic gap_set;
	logic apb_acc;

	// Address counter has no say in port choice here
	assign port_select = 4'hF;
	assign words_pending = |wreq_q;
	assign ack_hit = |(i_addr_ack & port_select);
	assign rrs_hit = |(i_read_restore_done & port_select);

	// Request and mixer blocks all clear, words pending plus data ready lets a request out
	assign req_ok = cycle_start_flag_q && !even_request_block_q &&
		!odd_request_block_q && !even_mixer_block_q &&
		!odd_mixer_block_q && words_pending &&
		(!write_q || buf_loaded_q);

	// Next requested word after the current one, circular scan
	always_comb begin
		logic [1:0] k;
		k = 2'h0;
		nxt_word = cnt_q;
		for (int i = 3; i >= 1; i--) begin
			k = cnt_q + 2'(i);
			if (wreq_q[k]) begin
				nxt_word = k;
			end
		end
	end
	assign inc_val = nxt_word - cnt_q;

	// Gap needed on parity match in two-port mode, always in single
	assign gap_set = ctrl_q[CTRL_TWO_BIT] ?
		(cnt_q[0] == inc_val[0]) : 1'b1;

	assign apb_acc = i_psel && i_penable;

	// APB slave: one wait state, answer from flops
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
		end else if (i_clk_en) begin
			o_pready <= apb_acc && !o_pready;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			if (apb_acc && !o_pready) begin
				// Decode on first access cycle
				if (i_paddr == CTRL_OFS) begin
					o_prdata <= {30'h0, ctrl_q};
				end else if (i_paddr == STAT_OFS) begin
					o_prdata <= {24'h0, wreq_q, cnt_q,
						gap_hold_q, cycle_active_q};
				end else begin
					o_pslverr <= 1'b1;
				end
			end
			// Writes take effect on the completing edge
			if (apb_acc && o_pready && i_pwrite &&
				i_paddr == CTRL_OFS) begin
				ctrl_q <= i_pwdata[1:0];
			end
		end
	end

	// Main sequencer
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= S_IDLE;
		end else if (i_clk_en) begin
			if (i_sync_rst) begin
				state_q <= S_IDLE;
			end else begin
				case (state_q)
				S_IDLE: begin
					if (i_host_start && ctrl_q[CTRL_EN_BIT]) begin
						state_q <= S_SETUP;
					end
				end
				S_SETUP: begin
					state_q <= write_q ? S_LOAD : S_REQ;
				end
				S_LOAD: begin
					state_q <= S_REQ;
				end
				S_REQ: begin
					if (ack_hit && o_storage_cycle_request != 4'h0) begin
						state_q <= S_ACKD;
					end
				end
				S_ACKD: begin
					state_q <= write_q ? S_WPULSE : S_RDWAIT;
				end
				S_WPULSE: begin
					state_q <= S_NEXT;
				end
				S_RDWAIT: begin
					// Word cycle finishes before the next one
					if (rrs_hit) begin
						state_q <= S_NEXT;
					end
				end
				S_NEXT: begin
					state_q <= gap_set ? S_GAP : S_CLR;
				end
				S_GAP: begin
					if (gap_cnt_q == 2'h1) begin
						state_q <= S_CLR;
					end
				end
				S_CLR: begin
					// Next word waits for acknowledge to drop
					if (!words_pending) begin
						state_q <= S_END;
					end else if (!(|i_addr_ack)) begin
						state_q <= write_q ? S_LOAD : S_REQ;
					end
				end
				S_END: begin
					// Writes also wait for every port to go free
					if (!(write_q && |i_port_occupied)) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
				endcase
			end
		end
	end

	// Request latches: address, type, word flops, counter
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= 2'h0;
			wreq_q <= 4'h0;
			write_q <= 1'b0;
			o_storage_addr <= '0;
		end else if (i_clk_en) begin
			if (i_sync_rst) begin
				wreq_q <= 4'h0;
			end else if (state_q == S_IDLE && i_host_start &&
				ctrl_q[CTRL_EN_BIT]) begin
				o_storage_addr <= i_host_addr[HADDR_W-1:2];
				cnt_q <= i_host_addr[1:0];
				wreq_q <= i_host_word_requests;
				write_q <= i_host_cycle_type;
			end else if (state_q == S_ACKD) begin
				wreq_q[cnt_q] <= 1'b0;
			end else if (state_q == S_NEXT) begin
				// Counter moves after restore on reads, after the write pulse on writes
				cnt_q <= nxt_word;
			end
		end
	end

	// Cycling flags
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cycle_start_flag_q <= 1'b0;
			cycle_active_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_sync_rst || state_q == S_IDLE) begin
				cycle_start_flag_q <= 1'b0;
				cycle_active_q <= 1'b0;
			end else if (state_q == S_SETUP) begin
				cycle_start_flag_q <= 1'b1;
				cycle_active_q <= 1'b1;
			end else if (state_q == S_END &&
				!(write_q && |i_port_occupied)) begin
				cycle_active_q <= 1'b0;
				cycle_start_flag_q <= 1'b0;
			end
		end
	end

	// Mixer and request blocks
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			even_mixer_block_q <= 1'b0;
			odd_mixer_block_q <= 1'b0;
			even_request_block_q <= 1'b0;
			odd_request_block_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_sync_rst) begin
				even_mixer_block_q <= 1'b0;
				odd_mixer_block_q <= 1'b0;
				even_request_block_q <= 1'b0;
				odd_request_block_q <= 1'b0;
			end else begin
				// Mixer blocks follow the selected acknowledge
				even_mixer_block_q <= ack_hit;
				odd_mixer_block_q <= ack_hit;
				if (state_q == S_ACKD) begin
					even_request_block_q <= 1'b1;
					odd_request_block_q <= 1'b1;
				end else if (state_q == S_CLR) begin
					even_request_block_q <= 1'b0;
					odd_request_block_q <= 1'b0;
				end
			end
		end
	end

	// Gap timer and hold, restore inhibit
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gap_hold_q <= 1'b0;
			gap_cnt_q <= 2'h0;
			restore_inhibit_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_sync_rst) begin
				gap_hold_q <= 1'b0;
				gap_cnt_q <= 2'h0;
				restore_inhibit_q <= 1'b0;
			end else if (state_q == S_NEXT && gap_set) begin
				gap_hold_q <= 1'b1;
				gap_cnt_q <= GAP_HOLD_CYCLES;
				restore_inhibit_q <= 1'b1;
			end else if (state_q == S_GAP && gap_cnt_q > 2'h1) begin
				gap_cnt_q <= gap_cnt_q - 2'h1;
			end else begin
				// Hold lets address lines settle before release
				gap_hold_q <= 1'b0;
				gap_cnt_q <= 2'h0;
				restore_inhibit_q <= (state_q == S_ACKD) ||
					(state_q == S_RDWAIT);
			end
		end
	end

	// Data buffer: write load, read capture, clears
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			buf_q <= '0;
			buf_loaded_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_sync_rst || state_q == S_IDLE) begin
				buf_q <= '0;
				buf_loaded_q <= 1'b0;
			end else if (state_q == S_LOAD) begin
				buf_q <= i_host_wdata;
				buf_loaded_q <= 1'b1;
			end else if (state_q == S_RDWAIT && rrs_hit) begin
				buf_q <= i_storage_rdata;
			end else if (state_q == S_CLR) begin
				buf_q <= '0;
				buf_loaded_q <= 1'b0;
			end
		end
	end

	// Storage side outputs
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_storage_cycle_request <= 4'h0;
			o_write_restart <= 4'h0;
			o_port_data_gate <= 4'h0;
			o_storage_wdata <= '0;
			ack_port_q <= 4'h0;
			o_word_addr <= 2'h0;
		end else if (i_clk_en) begin
			o_word_addr <= cnt_q;
			o_write_restart <= 4'h0;
			o_port_data_gate <= 4'h0;
			o_storage_wdata <= '0;
			if (i_sync_rst) begin
				o_storage_cycle_request <= 4'h0;
			end else begin
				// Request dropped as soon as any port answers
				o_storage_cycle_request <= (state_q == S_REQ &&
					req_ok && !ack_hit) ? 4'hF : 4'h0;
			end
			if (state_q == S_REQ && ack_hit) begin
				ack_port_q <= i_addr_ack & port_select;
			end
			if (state_q == S_WPULSE) begin
				o_write_restart <= ack_port_q;
				o_port_data_gate <= ack_port_q;
				o_storage_wdata <= buf_q;
			end
		end
	end

	// Processor side outputs
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_host_acknowledge <= 1'b0;
			o_host_data_valid <= 1'b0;
			o_host_rdata <= '0;
		end else if (i_clk_en) begin
			o_host_acknowledge <= !i_sync_rst && state_q == S_REQ &&
				ack_hit && o_storage_cycle_request != 4'h0;
			o_host_data_valid <= !i_sync_rst &&
				state_q == S_RDWAIT && rrs_hit;
			if (state_q == S_RDWAIT && rrs_hit) begin
				o_host_rdata <= i_storage_rdata;
			end else if (state_q == S_IDLE) begin
				o_host_rdata <= '0;
			end
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n || i_sync_rst);

	gap_hold_len_a: assert property (
		i_clk_en && state_q == S_NEXT && gap_set
		|=> gap_hold_q && restore_inhibit_q && gap_cnt_q == 2'h2)
		else $error("gap hold not started with two periods");
	single_gap_a: assert property (
		i_clk_en && state_q == S_NEXT && !ctrl_q[CTRL_TWO_BIT]
		|=> state_q == S_GAP)
		else $error("single-port next strobe without gap");
	all_ports_a: assert property (
		o_storage_cycle_request != 4'h0
		|-> o_storage_cycle_request == 4'hF)
		else $error("request not on all four buses");
	write_loaded_a: assert property (
		o_storage_cycle_request != 4'h0 && write_q |-> buf_loaded_q)
		else $error("write request before buffer loaded");
	ack_block_a: assert property (
		i_clk_en && state_q == S_ACKD
		|=> even_request_block_q && odd_request_block_q)
		else $error("request blocks not set after acknowledge");
	clr_reset_a: assert property (
		i_clk_en && state_q == S_CLR
		|=> !even_request_block_q && !odd_request_block_q &&
		buf_q == '0)
		else $error("delayed load did not clear");
	wreq_clear_a: assert property (
		i_clk_en && state_q == S_ACKD |=> !wreq_q[$past(cnt_q)])
		else $error("word flop not cleared at ack delay");
	idle_clear_a: assert property (
		state_q == S_IDLE && !cycle_active_q |-> buf_q == '0 ||
		$past(state_q) != S_IDLE)
		else $error("buffer not clear while idle");
	host_ack_a: assert property (
		o_host_acknowledge |-> $past(ack_hit))
		else $error("host acknowledge without storage acknowledge");
	write_end_a: assert property (
		i_clk_en && state_q == S_END && write_q && |i_port_occupied
		|=> cycle_active_q)
		else $error("write ended while port occupied");

	read_cov_c: cover property (o_host_data_valid && !write_q);
	write_cov_c: cover property (|o_write_restart);
	gap_cov_c: cover property (gap_hold_q && ctrl_q[CTRL_TWO_BIT]);
	end_cov_c: cover property ($fell(cycle_active_q));
endmodule

// ==== testbench/mcs_store_model.sv ====
`timescale 1ns/1ps
// Storage module stand-in: one word per request, answers on port 0
module mcs_store_model (
	input wire logic i_clk_sys,
	input wire logic i_is_write,
	input wire logic [3:0] i_dly,
	input wire logic [3:0] i_req,
	input wire logic [1:0] i_word,
	input wire logic [3:0] i_write_restart,
	input wire logic [35:0] i_wdata,
	output logic [3:0] o_ack,
	output logic [3:0] o_rs,
	output logic [3:0] o_occ,
	output logic [35:0] o_rdata
);
	logic [35:0] mem_q [4]; // Word store
	logic [3:0] cnt_q; // Response delay count
	logic [1:0] ph_q; // 0 wait request, 1 acked, 2 finishing
	initial begin
		for (int i = 0; i < 4; i++) begin
			mem_q[i] = 36'h5A5A5A5A0 + 36'(i);
		end
		{o_ack, o_rs, o_occ, cnt_q, ph_q} = '0;
		o_rdata = 36'h0;
	end
	// Data lines toggle while not presenting, so nothing stale looks valid
	always @(posedge i_clk_sys) begin
		// Skip the toggle on the edge that presents the read word
		if (o_rs == 4'h0 && !(ph_q == 2'h2 && !i_is_write &&
			cnt_q == i_dly))
			o_rdata <= ~o_rdata;
		case (ph_q)
		2'h0: begin
			// Restore level drops once the next request shows
			if (i_req != 4'h0)
				o_rs <= 4'h0;
			if (i_req == 4'hF && cnt_q == i_dly) begin
				o_ack <= 4'h1;
				o_occ <= 4'h1;
				ph_q <= 2'h1;
				cnt_q <= 4'h0;
			end else if (i_req == 4'hF)
				cnt_q <= cnt_q + 4'h1;
		end
		2'h1: if (i_req == 4'h0) begin
			o_ack <= 4'h0;
			ph_q <= 2'h2;
		end
		default: if (i_is_write && i_write_restart[0]) begin
			mem_q[i_word] <= i_wdata;
			o_occ <= 4'h0;
			ph_q <= 2'h0;
		end else if (!i_is_write && cnt_q == i_dly) begin
			o_rs <= 4'h1;
			o_rdata <= mem_q[i_word];
			o_occ <= 4'h0;
			ph_q <= 2'h0;
			cnt_q <= 4'h0;
		end else if (!i_is_write)
			cnt_q <= cnt_q + 4'h1;
		endcase
	end
endmodule

// ==== testbench/single_port_memory_cycle_sequencer_tb.sv ====
`timescale 1ns/1ps
module single_port_memory_cycle_sequencer_tb;
	import mcs_pkg::*;
	logic clk = 0, rst_n = 0, srst = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, start = 0, wr = 0, ack, dv;
	logic [3:0] hreq = 4'h0, sreq, gate, wrs, sack, srs, socc, dly = 4'h2;
	logic [21:0] haddr = 22'h0;
	logic [35:0] hwd = 36'h0, hrd, swd, srd, tmem [4];
	logic [19:0] saddr;
	logic [1:0] waddr;
	int fail_count = 0, n_compared = 0, n_ack = 0, n_dv = 0, gap = 0;
	logic [35:0] exp_q [$];
	logic [31:0] rd;
	logic err;
	logic ce = 1'b1, exp_gap = 1'b1; // Clock enable, gap expected
	always #20 clk = ~clk;
	mcs_seq i_dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_clk_en(ce),
		.i_sync_rst(srst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_host_start(start), .i_host_cycle_type(wr),
		.i_host_word_requests(hreq), .i_host_addr(haddr),
		.i_host_wdata(hwd), .o_host_acknowledge(ack),
		.o_host_data_valid(dv), .o_host_rdata(hrd),
		.o_storage_cycle_request(sreq), .o_storage_addr(saddr),
		.o_word_addr(waddr), .o_port_data_gate(gate),
		.o_write_restart(wrs), .o_storage_wdata(swd), .i_addr_ack(sack),
		.i_read_restore_done(srs), .i_storage_rdata(srd),
		.i_port_occupied(socc));
	mcs_store_model i_mem (.i_clk_sys(clk), .i_is_write(wr), .i_dly(dly),
		.i_req(sreq), .i_word(waddr), .i_write_restart(wrs), .i_wdata(swd),
		.o_ack(sack), .o_rs(srs), .o_occ(socc), .o_rdata(srd));
	// Value comparison, counted
	task automatic chk(input logic [35:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		// Only the watchdog bounds this wait
		do @(posedge clk); while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, pen} <= 2'b00;
	endtask
	// Wait for a one-cycle pulse, bounded
	task automatic wait_hi(ref logic s);
		repeat (400) begin
			@(posedge clk);
			if (s === 1'b1)
				return;
		end
		chk(36'h0, 36'h1, "pulse timeout");
	endtask
	// One host cycle; words served circularly from the start word
	task automatic host_op(input logic w, input logic [21:0] a,
		input logic [3:0] m);
		logic [1:0] ord [$];
		logic [1:0] x;
		for (int k = 0; k < 4; k++) begin
			x = a[1:0] + 2'(k);
			if (m[x])
				ord.push_back(x);
		end
		foreach (ord[k]) begin
			if (w)
				tmem[ord[k]] = 36'hC3C3C3C00 + 36'(ord[k]);
			else
				exp_q.push_back(tmem[ord[k]]);
		end
		@(posedge clk);
		{start, wr, hreq, haddr} <= {1'b1, w, m, a};
		hwd <= tmem[ord[0]];
		@(posedge clk);
		start <= 1'b0;
		foreach (ord[k]) begin
			wait_hi(ack);
			if (w && k + 1 < ord.size())
				hwd <= tmem[ord[k + 1]];
			if (!w)
				wait_hi(dv);
		end
		repeat (20) @(posedge clk);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(36'(rd[7:0] & 8'hF1), 36'h0, "status idle");
	endtask
	// Continuous watch on the storage side and read data
	always @(posedge clk) begin
		if (rst_n && !srst) begin
			gap <= dv ? 0 : gap + 1;
			// Writes give no data valid, so only read acks count
			n_ack <= n_ack + int'(ack === 1'b1 && !wr);
			n_dv <= n_dv + int'(dv === 1'b1);
			if (sreq !== 4'h0)
				chk(36'(sreq), 36'hF, "request on all buses");
			if (sreq === 4'hF)
				chk(36'(saddr), 36'(haddr[21:2]), "storage addr");
			if (wrs !== 4'h0)
				chk(36'(gate), 36'(wrs), "write gate");
			if (sreq === 4'hF && $past(sreq) === 4'h0 && n_ack > 0 && !wr) begin
				chk(36'(n_dv), 36'(n_ack), "word not finished");
				// Only gaps inside one host cycle are judged
				if (gap < 10)
					chk(36'(gap >= 3), 36'(exp_gap), "gap length");
			end
			if (dv === 1'b1)
				chk(hrd, exp_q.size() ? exp_q.pop_front() : 36'hX, "rdata");
		end
	end
	// Verdict and end of run
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		end_of_test;
	end
	initial begin
		for (int i = 0; i < 4; i++)
			tmem[i] = 36'h5A5A5A5A0 + 36'(i);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(36'(rd), 36'(CTRL_RST), "ctrl reset");
		apb(1'b1, STAT_OFS, 32'hFF);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(36'(rd), 36'h0, "status read-only");
		apb(1'b0, 8'h08, 32'h0);
		chk(36'({err, rd}), 36'h100000000, "unmapped");
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (16) @(posedge clk);
		chk(36'(sreq), 36'h0, "start while disabled");
		apb(1'b1, CTRL_OFS, 32'h1);
		// A start seen while frozen must be lost
		@(posedge clk);
		{ce, start} <= 2'b01;
		@(posedge clk);
		start <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		chk(36'(sreq), 36'h0, "start while frozen");
		host_op(1'b0, 22'h2A5C0, 4'hF);
		host_op(1'b0, 22'h01230, 4'hD);
		dly <= 4'h9;
		host_op(1'b1, 22'h3C002, 4'hF);
		dly <= 4'h2;
		host_op(1'b0, 22'h00011, 4'hF);
		apb(1'b1, CTRL_OFS, 32'h3);
		host_op(1'b0, 22'h10000, 4'h5);
		// Word 0 then word 1: parities differ, so no gap
		exp_gap <= 1'b0;
		host_op(1'b0, 22'h10000, 4'h3);
		exp_gap <= 1'b1;
		@(posedge clk);
		{start, wr, hreq} <= {1'b1, 1'b0, 4'hF};
		@(posedge clk);
		start <= 1'b0;
		wait (sreq === 4'hF);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk(36'(sreq), 36'h0, "sync reset request");
		apb(1'b0, STAT_OFS, 32'h0);
		chk(36'(rd[7:0] & 8'hF3), 36'h0, "sync reset status");
		exp_q.delete();
		end_of_test;
	end
endmodule
